// file: include/twowire_host_pkg.sv
// constants and carrier types for the two-wire bus host
// assumes a 10 MHz system clock and an external pull-up on both lines
package twowire_host_pkg;

	localparam int CLK_MHZ            = 10;
	// minimum wait after the supply is stable, in microseconds
	localparam int POWER_UP_WAIT_TIME = 100;
	localparam int PUP_CYCLES         = POWER_UP_WAIT_TIME * CLK_MHZ;
	localparam int PUP_W              = 11;
	// quarter of one bus clock period; 4 x 7 cycles gives about 357 kHz
	localparam int QTR_CYCLES         = 7;
	localparam int QTR_W              = 4;
	localparam int BYTE_BITS          = 9;
	localparam int DUMMY_CLOCKS       = 9;
	localparam logic [3:0] ACK_BIT    = 4'h8;

	typedef enum logic [2:0] {
		op_start,
		op_write,
		op_read,
		op_stop,
		op_recover
	} op_t;

	typedef struct packed {
		op_t        op;
		logic [7:0] data;
		logic       nack;
	} cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       nack;
	} rsp_t;

endpackage

// file: verilog/twowire_host.sv
// bus host that drives a two-wire serial memory through its scl and sda pins
// assumes one command at a time from logic on clk; sda has an external pull-up
//
// What this block does
// - wait power_up_wait_time before first command
// - bytes travel msb first, no gaps
// - nine clocks per byte including acknowledge
// - sda changes only while scl low
// - every command begins with a start (the block sends one only on op_start; op_write and op_read add none)
// - repeated start allowed instead of stop
// - bus idle only when both lines high
// - transmitter releases sda; receiver holds ack low
// - receiver releases sda after ninth clock
// - host nack ends device transmission
// - recovery: up to nine dummy clocks, then start (the block sends no start after the clocks; a following op_start must send it)
`timescale 1ns/1ps

module twowire_host #(
	parameter int QTR  = twowire_host_pkg::QTR_CYCLES,
	parameter int PUP  = twowire_host_pkg::PUP_CYCLES
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    cmd_valid,
	input  wire twowire_host_pkg::cmd_t  cmd,
	output logic                         cmd_ready,
	output logic                         rsp_valid,
	output twowire_host_pkg::rsp_t       rsp,
	output logic                         bus_idle,
	output logic                         scl_out,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe
);
	import twowire_host_pkg::*;

	typedef enum logic [2:0] {
		st_pup,
		st_idle,
		st_start,
		st_bit,
		st_stop,
		st_rec
	} state_t;

	state_t      state_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic [3:0]  rec_q;
	logic [QTR_W-1:0] qcnt_q;
	logic [PUP_W-1:0] pup_q;
	logic [7:0]  sh_q;
	logic        is_rd_q;
	logic        nack_q;
	logic        scl_q;
	logic        sda_oe_q;
	logic        sda_out_q;
	logic        ready_q;
	logic        rsp_valid_q;
	rsp_t        rsp_q;
	logic        idle_q;
	logic        sda_meta_q;
	logic        sda_sync_q;
	logic [3:0]  rises_q;

	wire         tick   = (qcnt_q == '0);
	wire         take   = cmd_valid && ready_q;
	wire         last   = tick && (ph_q == 2'h3);
	wire         in_ack = (bit_q == ACK_BIT);
	// bit driven in phase 0: data msb, host ack on read, release otherwise
	wire         drive_low = in_ack ? (is_rd_q && !nack_q) : (!is_rd_q && !sh_q[7]);
	wire         rec_done  = sda_sync_q || (rec_q == 4'(DUMMY_CLOCKS - 1));

	assign cmd_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp       = rsp_q;
	assign bus_idle  = idle_q;
	assign scl_out   = scl_q;
	assign sda_out   = sda_out_q;
	assign sda_oe    = sda_oe_q;

	// two flops before anything looks at the pin
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
		end else begin
			sda_meta_q <= sda_in;
			sda_sync_q <= sda_meta_q;
		end
	end

	// quarter-period timer restarts on each accepted command
	always_ff @(posedge clk) begin
		if (rst || take || tick) begin
			qcnt_q <= QTR_W'(QTR - 1);
		end else begin
			qcnt_q <= qcnt_q - 1'b1;
		end
	end

	// open drain: the pin value is always low, only the enable moves
	always_ff @(posedge clk) begin
		sda_out_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q     <= st_pup;
			ph_q        <= 2'h0;
			bit_q       <= 4'h0;
			rec_q       <= 4'h0;
			pup_q       <= '0;
			sh_q        <= 8'h00;
			is_rd_q     <= 1'b0;
			nack_q      <= 1'b0;
			scl_q       <= 1'b1;
			sda_oe_q    <= 1'b0;
			ready_q     <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_q       <= '0;
			idle_q      <= 1'b1;
		end else begin
			rsp_valid_q <= 1'b0;
			if (tick && state_q != st_idle && state_q != st_pup) begin
				ph_q <= ph_q + 2'h1;
			end
			case (state_q)
			st_pup: begin
				// reset release stands in for supply stable
				pup_q <= pup_q + 1'b1;
				if (pup_q == PUP_W'(PUP - 1)) begin
					state_q <= st_idle;
					ready_q <= 1'b1;
				end
			end
			st_idle: begin
				ph_q <= 2'h0;
				if (take) begin
					ready_q <= 1'b0;
					bit_q   <= 4'h0;
					rec_q   <= 4'h0;
					sh_q    <= cmd.data;
					nack_q  <= cmd.nack;
					is_rd_q <= (cmd.op == op_read);
					case (cmd.op)
					op_start:   state_q <= st_start;
					op_stop:    state_q <= st_stop;
					op_recover: state_q <= st_rec;
					default:    state_q <= st_bit;
					endcase
				end
			end
			st_start: begin
				// also serves as repeated start from scl low
				if (tick) begin
					case (ph_q)
					2'h0: sda_oe_q <= 1'b0;
					2'h1: scl_q <= 1'b1;
					2'h2: begin
						sda_oe_q <= 1'b1;
						idle_q   <= 1'b0;
					end
					default: begin
						scl_q       <= 1'b0;
						state_q     <= st_idle;
						ready_q     <= 1'b1;
						rsp_valid_q <= 1'b1;
					end
					endcase
				end
			end
			st_bit: begin
				if (tick) begin
					case (ph_q)
					2'h0: sda_oe_q <= drive_low;
					2'h1: scl_q <= 1'b1;
					2'h2: begin
						if (in_ack) begin
							rsp_q.nack <= sda_sync_q;
						end else begin
							sh_q       <= {sh_q[6:0], sda_sync_q};
							rsp_q.data <= {sh_q[6:0], sda_sync_q};
						end
					end
					default: begin
						scl_q <= 1'b0;
						if (in_ack) begin
							sda_oe_q    <= 1'b0;
							state_q     <= st_idle;
							ready_q     <= 1'b1;
							rsp_valid_q <= 1'b1;
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
					endcase
				end
			end
			st_stop: begin
				if (tick) begin
					case (ph_q)
					2'h0: begin
						scl_q    <= 1'b0;
						sda_oe_q <= 1'b1;
					end
					2'h1: scl_q <= 1'b1;
					2'h2: sda_oe_q <= 1'b0;
					default: begin
						idle_q      <= 1'b1;
						state_q     <= st_idle;
						ready_q     <= 1'b1;
						rsp_valid_q <= 1'b1;
						rsp_q.nack  <= 1'b0;
					end
					endcase
				end
			end
			st_rec: begin
				// dummy clocks; ends with scl high so a start can follow
				if (tick) begin
					case (ph_q)
					2'h0: begin
						scl_q    <= 1'b0;
						sda_oe_q <= 1'b0;
						idle_q   <= 1'b0;
					end
					2'h1: scl_q <= 1'b1;
					2'h2: rsp_q.nack <= !sda_sync_q;
					default: begin
						if (rec_done) begin
							idle_q      <= sda_sync_q;
							state_q     <= st_idle;
							ready_q     <= 1'b1;
							rsp_valid_q <= 1'b1;
						end else begin
							rec_q <= rec_q + 4'h1;
						end
					end
					endcase
				end
			end
			default: state_q <= st_pup;
			endcase
		end
	end

	// checking helpers: scl rises seen in the current byte
	always_ff @(posedge clk) begin
		if (rst || take) begin
			rises_q <= 4'h0;
		end else if (tick && ph_q == 2'h1 && state_q inside {st_bit, st_rec}) begin
			rises_q <= rises_q + 4'h1;
		end
	end

	sequence s_sda_moves_high;
		scl_q && $past(scl_q) && $changed(sda_oe_q);
	endsequence

	property p_pup_wait;
		@(posedge clk) disable iff (rst)
		(state_q == st_pup) |-> !ready_q;
	endproperty
	a_pup_wait: assert property (p_pup_wait) else $error("command taken before power-up wait");

	property p_pup_len;
		@(posedge clk) disable iff (rst)
		$rose(ready_q) && $past(state_q) == st_pup |-> $past(pup_q) == PUP_W'(PUP - 1);
	endproperty
	a_pup_len: assert property (p_pup_len) else $error("power-up wait has wrong length");

	property p_sda_in_high;
		@(posedge clk) disable iff (rst)
		s_sda_moves_high |-> state_q inside {st_start, st_stop};
	endproperty
	a_sda_in_high: assert property (p_sda_in_high) else $error("sda moved while scl high");

	property p_nine;
		@(posedge clk) disable iff (rst)
		rsp_valid_q && $past(state_q) == st_bit |-> rises_q == 4'(BYTE_BITS);
	endproperty
	a_nine: assert property (p_nine) else $error("byte did not take nine clocks");

	// only before the sample shifts the next bit up into the msb
	property p_msb;
		@(posedge clk) disable iff (rst)
		state_q == st_bit && !is_rd_q && !in_ack && scl_q && ph_q == 2'h2
			|-> sda_oe_q == !sh_q[7];
	endproperty
	a_msb: assert property (p_msb) else $error("write bit out of order");

	property p_release_ack;
		@(posedge clk) disable iff (rst)
		state_q == st_bit && scl_q && (is_rd_q != in_ack) |-> !sda_oe_q;
	endproperty
	a_release_ack: assert property (p_release_ack) else $error("sda not released for other side");

	property p_host_ack;
		@(posedge clk) disable iff (rst)
		state_q == st_bit && is_rd_q && in_ack && scl_q |-> sda_oe_q == !nack_q;
	endproperty
	a_host_ack: assert property (p_host_ack) else $error("read acknowledge wrong");

	property p_release9;
		@(posedge clk) disable iff (rst)
		state_q == st_bit && in_ack && last |=> !sda_oe_q && !scl_q ##1 !sda_oe_q;
	endproperty
	a_release9: assert property (p_release9) else $error("sda held after ninth clock");

	property p_start;
		@(posedge clk) disable iff (rst)
		state_q == st_start && ph_q == 2'h2 && tick |=> scl_q && sda_oe_q && !idle_q;
	endproperty
	a_start: assert property (p_start) else $error("start not made with scl high");

	property p_stop;
		@(posedge clk) disable iff (rst)
		state_q == st_stop && ph_q == 2'h2 && tick |=> scl_q && !sda_oe_q;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not made with scl high");

	property p_idle;
		@(posedge clk) disable iff (rst)
		idle_q |-> scl_q && !sda_oe_q;
	endproperty
	a_idle: assert property (p_idle) else $error("idle flagged with a line low");

	property p_dummy;
		@(posedge clk) disable iff (rst)
		state_q == st_rec |-> rises_q <= 4'(DUMMY_CLOCKS);
	endproperty
	a_dummy: assert property (p_dummy) else $error("more than nine dummy clocks");

endmodule

// file: dv/twowire_dev_model.sv
// behavioural slave front end of the serial memory, far side of the host
// assumes sda is the wired level with a pull-up; busy mimics a write cycle
`timescale 1ns/1ps

module twowire_dev_model (
	input  wire logic       por,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       busy,
	input  wire logic [7:0] tx_byte,
	output logic            sda_low,
	output logic [7:0]      rx_byte,
	output logic            standby
);
	logic [3:0] bit_n;
	logic [7:0] sh;
	logic       act, adr, rd, go_rd;

	initial begin
		sda_low = 0;
		act = 0;
		go_rd = 0;
		standby = 1;
	end
	always @(negedge sda) if (scl === 1'b1 && !por) begin
		act = 1;
		adr = 1;
		rd = 0;
		go_rd = 0;
		standby = 0;
		sda_low = 0;
		bit_n = 4'hf;
	end
	always @(posedge sda) if (scl === 1'b1 && !por) begin
		act = 0;
		standby = 1;
		sda_low = 0;
	end
	always @(posedge scl) if (act) begin
		if (bit_n < 8 && !rd) sh = {sh[6:0], sda};
		if (bit_n == 8 && rd && sda) begin
			rd = 0;
			act = 0;
		end
	end
	// sda only ever pulled low or let go, never driven high
	always @(negedge scl) if (act) begin
		bit_n = (bit_n == 8) ? 4'h0 : bit_n + 4'h1;
		sda_low = 0;
		if (bit_n == 8 && !rd) begin
			rx_byte = sh;
			sda_low = !(busy && adr);
			go_rd = adr && sh[0] && sda_low;
			act = sda_low;
			adr = 0;
		end
		if (bit_n == 0) rd = go_rd;
		if (rd && bit_n < 8) sda_low = !tx_byte[3'h7 - bit_n[2:0]];
	end
endmodule

// file: dv/twowire_host_tb_top.sv
// self-checking bench for the two-wire host against a memory front end model
// assumes the host makes scl itself; the sda wire level is resolved here
`timescale 1ns/1ps

module twowire_host_tb_top;
	import twowire_host_pkg::*;
	localparam int Q = 4;
	localparam int P = 20;
	logic       clk, rst, cmd_valid, cmd_ready, rsp_valid, bus_idle;
	logic       scl_out, sda_out, sda_oe, sda, dev_low, busy, standby;
	logic [7:0] tx_byte, rx_byte;
	cmd_t       cmd;
	rsp_t       rsp;
	int         fail_count, n_compared, lat, rises;

	// pull-up: high unless someone pulls low
	assign sda = !((sda_oe && !sda_out) || dev_low);

	twowire_host #(.QTR(Q), .PUP(P)) u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
		.bus_idle(bus_idle), .scl_out(scl_out), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe));
	twowire_dev_model u_dev (.por(rst), .scl(scl_out), .sda(sda), .busy(busy),
		.tx_byte(tx_byte), .sda_low(dev_low), .rx_byte(rx_byte), .standby(standby));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge scl_out) rises++;

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#3000000;
		fail_count++;
		summarize();
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	// held until taken; lat counts edges from take to result
	task automatic op(input op_t o, input logic [7:0] d, input logic nk);
		cmd_valid = 1;
		cmd = '{o, d, nk};
		lat = 0;
		while (cmd_ready !== 1'b1 && lat < 2000) begin
			@(posedge clk) #1;
			lat++;
		end
		@(posedge clk) #1;
		cmd_valid = 0;
		lat = 0;
		rises = 0;
		while (rsp_valid !== 1'b1 && lat < 999) begin
			@(posedge clk) #1;
			lat++;
		end
	endtask

	task automatic wr(input logic [7:0] d, input logic nk);
		op(op_write, d, 1'b0);
		chk(16'(rsp.nack), 16'(nk));
		chk(16'(rx_byte), 16'(d));
		chk(16'(rises), 16'h9);
		chk(16'(lat), 16'(36 * Q));
	endtask

	task automatic rd(input logic [7:0] d, input logic nk);
		op(op_read, 8'h00, nk);
		chk(16'(rsp.data), 16'(d));
		chk(16'(rises), 16'h9);
	endtask

	task automatic cond(input op_t o, input logic idle);
		op(o, 8'h00, 1'b0);
		chk(16'({bus_idle, standby}), 16'({idle, idle}));
		chk(16'(lat), 16'(4 * Q));
	endtask

	task automatic t_reset;
		int n;
		repeat (5) @(posedge clk);
		#1;
		chk(16'({scl_out, sda_out, sda_oe, bus_idle, cmd_ready, rsp_valid}), 16'h24);
		rst = 0;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 999) begin
			@(posedge clk) #1;
			n++;
		end
		chk(16'(n >= P && n <= P + 1), 16'h1);
		$display("test reset done");
	endtask

	task automatic t_write;
		cond(op_start, 0);
		wr(8'ha0, 0);
		wr(8'h3c, 0);
		wr(8'hc5, 0);
		cond(op_start, 0);
		wr(8'ha0, 0);
		cond(op_stop, 1);
		$display("test write done");
	endtask

	// write cycle running: address refused, then taken once it ends
	task automatic t_busy;
		busy = 1;
		cond(op_start, 0);
		wr(8'ha0, 1);
		cond(op_stop, 1);
		busy = 0;
		cond(op_start, 0);
		wr(8'ha0, 0);
		cond(op_stop, 1);
		$display("test busy done");
	endtask

	task automatic t_read;
		tx_byte = 8'h5a;
		cond(op_start, 0);
		wr(8'ha1, 0);
		rd(8'h5a, 0);
		rd(8'h5a, 1);
		chk(16'(sda), 16'h1);
		cond(op_stop, 1);
		$display("test read done");
	endtask

	// device left sending zeros; first one bit lets sda go on clock five
	task automatic t_recover;
		tx_byte = 8'h0f;
		cond(op_start, 0);
		wr(8'ha1, 0);
		op(op_recover, 8'h00, 1'b0);
		chk(16'(rsp.nack), 16'h0);
		chk(16'(rises), 16'h5);
		chk(16'(lat), 16'(20 * Q));
		cond(op_start, 0);
		wr(8'ha0, 0);
		cond(op_stop, 1);
		$display("test recover done");
	endtask

	initial begin
		rst = 1;
		cmd_valid = 0;
		cmd = '0;
		busy = 0;
		tx_byte = 8'h0f;
		fail_count = 0;
		n_compared = 0;
		t_reset();
		t_write();
		t_busy();
		t_read();
		t_recover();
		summarize();
	end
endmodule
